// ---- pkg/usbd_pkg.sv ----
// Constants, state codes and carriers for the endpoint descriptor and frame logic.
// Assumes a byte-wide SRAM port with one cycle of read latency.
package usbd_pkg;

    // Descriptor byte offsets
    localparam logic [2:0] OFS_CTRL = 3'h1;
    localparam logic [2:0] OFS_COUNT_LO = 3'h2;
    localparam logic [2:0] OFS_COUNT_HI = 3'h3;
    localparam logic [2:0] OFS_PTRL = 3'h4;
    localparam logic [2:0] OFS_PTRH = 3'h5;
    localparam logic [2:0] OFS_AUXL = 3'h6;
    localparam logic [2:0] OFS_AUXH = 3'h7;

    // Descriptor table layout
    localparam int DESC_SHIFT = 4;
    localparam logic [15:0] IN_DESC_OFS = 16'h0008;
    localparam logic [15:0] FRAME_OFS_LOW = 16'h0000;
    localparam logic [15:0] FRAME_OFS_HIGH = 16'h0001;

    // Control byte fields
    localparam int CTRL_TYPE_MSB = 7;
    localparam int CTRL_TYPE_LSB = 6;
    localparam int CTRL_MULTI_BIT = 5;
    localparam logic [1:0] TYPE_ISO = 2'h3;

    // High count byte and high frame byte fields
    localparam int COUNT_HIGH_KEEP_LSB = 2;
    localparam int FRAME_ERR_BIT = 7;
    localparam logic [3:0] FRAME_RSVD = 4'h0;

    // Payload sizes
    localparam logic [9:0] PAYLOAD_MIN = 10'h008;
    localparam logic [9:0] PAYLOAD_MAX = 10'h3FF;
    localparam logic [2:0] SIZE_CODE_MAX = 3'h7;

    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_RD   = 10'h002,
        ST_WAIT = 10'h004,
        ST_CALC = 10'h008,
        ST_WR   = 10'h010,
        ST_FIN  = 10'h020,
        ST_FNL  = 10'h040,
        ST_FNH  = 10'h080,
        ST_SPR0 = 10'h100,
        ST_SPR1 = 10'h200
    } usbd_state_t;

    typedef struct packed {
        logic [10:0] frame;
        logic error;
    } usbd_sof_t;

    typedef struct packed {
        logic [3:0] ep;
        logic is_in;
        logic [9:0] count;
    } usbd_txn_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } usbd_mem_req_t;

endpackage

// ---- rtl/usbd_payload_clip.sv ----
// Decodes an endpoint's payload size code and clips a packet byte count to it.
// Assumes the control byte has already been fetched from the descriptor.
`timescale 1ns/1ps
module usbd_payload_clip (
    // Descriptor control byte and packet size
    input wire logic [7:0] ctrl_i,
    input wire logic [9:0] count_i,
    // Results
    output logic [9:0] max_payload_o,
    output logic [9:0] clipped_o,
    output logic short_o
);
    logic [2:0] code;
    logic iso;

    always_comb begin
        iso = (ctrl_i[usbd_pkg::CTRL_TYPE_MSB:usbd_pkg::CTRL_TYPE_LSB] == usbd_pkg::TYPE_ISO);
        // Only isochronous endpoints may use the top size code bit
        code = iso ? ctrl_i[2:0] : {1'b0, ctrl_i[1:0]};
        if (code == usbd_pkg::SIZE_CODE_MAX) begin
            max_payload_o = usbd_pkg::PAYLOAD_MAX;
        end else begin
            max_payload_o = 10'(usbd_pkg::PAYLOAD_MIN << code);
        end
        // Bytes beyond the payload are dropped
        clipped_o = (count_i > max_payload_o) ? max_payload_o : count_i;
        short_o = (clipped_o < max_payload_o);
    end
endmodule

// ---- rtl/usbd_desc_frame.sv ----
// Endpoint descriptor walker and start-of-frame recorder for a USB device.
// Assumes a byte SRAM with one cycle read latency and software-built descriptors.
`timescale 1ns/1ps
module usbd_desc_frame (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Configuration
    input wire logic [15:0] descriptor_table_base_i,
    input wire logic [3:0] highest_endpoint_index_i,
    // Start-of-frame from the packet decoder
    input wire logic sof_valid_i,
    input wire usbd_pkg::usbd_sof_t sof_i,
    // Finished packet from the protocol engine
    input wire logic txn_valid_i,
    input wire usbd_pkg::usbd_txn_t txn_i,
    output logic txn_ready_o,
    // Packet results
    output logic txn_done_o,
    output logic [15:0] endpoint_buffer_pointer_o,
    output logic [9:0] accepted_count_o,
    output logic xfer_complete_o,
    output logic txn_irq_o,
    // Frame state
    output logic [10:0] sof_frame_number_o,
    output logic sof_frame_error_o,
    // SRAM port
    output usbd_pkg::usbd_mem_req_t mem_req_o,
    input wire logic [7:0] mem_rdata_i
);
    typedef struct packed {
        usbd_pkg::usbd_state_t st;
        logic [2:0] idx;
        logic rdv;
        logic [2:0] rdi;
        usbd_pkg::usbd_txn_t txn;
        logic [7:0][7:0] desc;
        logic sof_pend;
        usbd_pkg::usbd_sof_t sof;
        usbd_pkg::usbd_sof_t fw;
        logic [15:0] wword;
        logic cpend;
        logic done;
        logic cmpl;
        logic irq;
        logic [15:0] ptr;
        logic [9:0] taken;
    } usbd_core_t;

    usbd_core_t state_reg;
    usbd_core_t state_next;
    logic [9:0] max_payload;
    logic [9:0] clipped;
    logic short_pkt;
    logic multi;
    logic [15:0] ep_base;
    logic [15:0] frame_base;
    logic [15:0] aux_word;
    logic [15:0] in_total;
    logic [9:0] out_total;

    usbd_payload_clip u_clip (
        .ctrl_i(state_reg.desc[usbd_pkg::OFS_CTRL]),
        .count_i(state_reg.txn.count),
        .max_payload_o(max_payload),
        .clipped_o(clipped),
        .short_o(short_pkt)
    );

    always_comb begin
        multi = state_reg.desc[usbd_pkg::OFS_CTRL][usbd_pkg::CTRL_MULTI_BIT];
        ep_base = descriptor_table_base_i
            + (16'(state_reg.txn.ep) << usbd_pkg::DESC_SHIFT)
            + (state_reg.txn.is_in ? usbd_pkg::IN_DESC_OFS : 16'h0000);
        frame_base = descriptor_table_base_i
            + (16'({1'b0, highest_endpoint_index_i} + 5'h01) << usbd_pkg::DESC_SHIFT);
        aux_word = {state_reg.desc[usbd_pkg::OFS_AUXH], state_reg.desc[usbd_pkg::OFS_AUXL]};
        in_total = aux_word + 16'(clipped);
        // Running OUT count lives in the 10-bit byte counter, so a total past 1023 wraps
        out_total = multi
            ? ({state_reg.desc[usbd_pkg::OFS_COUNT_HI][1:0],
                state_reg.desc[usbd_pkg::OFS_COUNT_LO]} + clipped)
            : clipped;
    end

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.cmpl = 1'b0;
        state_next.irq = 1'b0;
        state_next.rdv = 1'b0;
        if (state_reg.rdv) begin
            state_next.desc[state_reg.rdi] = mem_rdata_i;
        end
        if (sof_valid_i) begin
            state_next.sof = sof_i;
            state_next.sof_pend = 1'b1;
        end
        unique case (state_reg.st)
            usbd_pkg::ST_IDLE: begin
                if (state_reg.sof_pend) begin
                    state_next.fw = state_reg.sof;
                    // A new frame in this cycle keeps the request alive
                    state_next.sof_pend = sof_valid_i;
                    state_next.st = usbd_pkg::ST_FNL;
                end else if (txn_valid_i) begin
                    state_next.txn = txn_i;
                    state_next.idx = usbd_pkg::OFS_CTRL;
                    state_next.st = usbd_pkg::ST_RD;
                end
            end
            usbd_pkg::ST_RD: begin
                state_next.rdv = 1'b1;
                state_next.rdi = state_reg.idx;
                // Control byte is in hand by the time the pointer high byte is fetched
                if ((state_reg.idx == usbd_pkg::OFS_PTRH && !multi)
                        || state_reg.idx == usbd_pkg::OFS_AUXH) begin
                    state_next.st = usbd_pkg::ST_WAIT;
                end else begin
                    state_next.idx = state_reg.idx + 3'h1;
                end
            end
            usbd_pkg::ST_WAIT: begin
                state_next.st = usbd_pkg::ST_CALC;
            end
            usbd_pkg::ST_CALC: begin
                state_next.ptr = {state_reg.desc[usbd_pkg::OFS_PTRH],
                                  state_reg.desc[usbd_pkg::OFS_PTRL]};
                state_next.taken = clipped;
                state_next.cpend = short_pkt || ({6'h00, out_total} >= aux_word);
                if (state_reg.txn.is_in && multi) begin
                    state_next.wword = in_total;
                    state_next.idx = usbd_pkg::OFS_AUXL;
                    state_next.cpend = short_pkt;
                    state_next.st = usbd_pkg::ST_WR;
                end else if (!state_reg.txn.is_in) begin
                    state_next.wword = {
                        state_reg.desc[usbd_pkg::OFS_COUNT_HI][7:usbd_pkg::COUNT_HIGH_KEEP_LSB],
                        out_total};
                    state_next.idx = usbd_pkg::OFS_COUNT_LO;
                    state_next.st = usbd_pkg::ST_WR;
                end else begin
                    state_next.st = usbd_pkg::ST_FIN;
                end
            end
            usbd_pkg::ST_WR: begin
                if (state_reg.idx[0]) begin
                    state_next.st = usbd_pkg::ST_FIN;
                end else begin
                    state_next.idx = state_reg.idx + 3'h1;
                end
            end
            usbd_pkg::ST_FIN: begin
                state_next.done = 1'b1;
                state_next.cmpl = multi && state_reg.cpend;
                // Intermediate packets of a multipacket transfer stay silent
                state_next.irq = !multi || state_reg.cpend;
                state_next.st = usbd_pkg::ST_IDLE;
            end
            usbd_pkg::ST_FNL: begin
                state_next.st = usbd_pkg::ST_FNH;
            end
            usbd_pkg::ST_FNH: begin
                state_next.st = usbd_pkg::ST_IDLE;
            end
            default: begin
                state_next.st = usbd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
            state_reg.st <= usbd_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        mem_req_o = '0;
        unique case (state_reg.st)
            usbd_pkg::ST_RD: begin
                mem_req_o.addr = ep_base + 16'(state_reg.idx);
                mem_req_o.re = 1'b1;
            end
            usbd_pkg::ST_WR: begin
                mem_req_o.addr = ep_base + 16'(state_reg.idx);
                mem_req_o.wdata = state_reg.idx[0] ? state_reg.wword[15:8]
                                                   : state_reg.wword[7:0];
                mem_req_o.we = 1'b1;
            end
            usbd_pkg::ST_FNL: begin
                mem_req_o.addr = frame_base + usbd_pkg::FRAME_OFS_LOW;
                mem_req_o.wdata = state_reg.fw.frame[7:0];
                mem_req_o.we = 1'b1;
            end
            usbd_pkg::ST_FNH: begin
                mem_req_o.addr = frame_base + usbd_pkg::FRAME_OFS_HIGH;
                mem_req_o.wdata = {state_reg.fw.error, usbd_pkg::FRAME_RSVD,
                                   state_reg.fw.frame[10:8]};
                mem_req_o.we = 1'b1;
            end
            default: begin
                mem_req_o = '0;
            end
        endcase
    end

    assign txn_ready_o = (state_reg.st == usbd_pkg::ST_IDLE) && !state_reg.sof_pend;
    assign txn_done_o = state_reg.done;
    assign endpoint_buffer_pointer_o = state_reg.ptr;
    assign accepted_count_o = state_reg.taken;
    assign xfer_complete_o = state_reg.cmpl;
    assign txn_irq_o = state_reg.irq;
    assign sof_frame_number_o = state_reg.sof.frame;
    assign sof_frame_error_o = state_reg.sof.error;

    sequence seq_frame_pair;
        (state_reg.st == usbd_pkg::ST_FNL && mem_req_o.we) ##1
        (state_reg.st == usbd_pkg::ST_FNH && mem_req_o.we);
    endsequence

    chk_desc_first_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        txn_valid_i && txn_ready_o |=> mem_req_o.re && mem_req_o.addr ==
            descriptor_table_base_i + (16'($past(txn_i.ep)) << usbd_pkg::DESC_SHIFT)
            + ($past(txn_i.is_in) ? usbd_pkg::IN_DESC_OFS : 16'h0000) + 16'h0001)
        else $error("descriptor fetch address wrong");
    chk_ptr_from_desc: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        txn_done_o |-> endpoint_buffer_pointer_o == {state_reg.desc[usbd_pkg::OFS_PTRH],
                                                     state_reg.desc[usbd_pkg::OFS_PTRL]})
        else $error("buffer pointer does not match descriptor");
    chk_aux_pair_order: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        state_reg.st == usbd_pkg::ST_WR && !state_reg.idx[0] |=>
            state_reg.st == usbd_pkg::ST_WR && state_reg.idx[0])
        else $error("word write not low then high");
    chk_in_total_sum: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        state_reg.st == usbd_pkg::ST_CALC && state_reg.txn.is_in && multi |=>
            state_reg.wword == $past(in_total) && state_reg.idx == usbd_pkg::OFS_AUXL)
        else $error("IN running total wrong");
    chk_aux_untouched: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (mem_req_o.re || mem_req_o.we) && state_reg.st != usbd_pkg::ST_FNL
            && state_reg.st != usbd_pkg::ST_FNH && state_reg.idx >= usbd_pkg::OFS_AUXL |-> multi)
        else $error("auxiliary bytes touched without multipacket");
    chk_sof_capture: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        sof_valid_i |=> sof_frame_number_o == $past(sof_i.frame)
            && sof_frame_error_o == $past(sof_i.error))
        else $error("frame number not captured");
    chk_frame_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        seq_frame_pair |-> mem_req_o.addr == frame_base + usbd_pkg::FRAME_OFS_HIGH
            && mem_req_o.wdata[6:3] == usbd_pkg::FRAME_RSVD
            && mem_req_o.wdata[usbd_pkg::FRAME_ERR_BIT] == state_reg.fw.error)
        else $error("high frame byte wrong");
    chk_sof_reaches_mem: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        sof_valid_i |-> ##[1:16] (state_reg.st == usbd_pkg::ST_FNL && mem_req_o.we))
        else $error("frame not written to memory");
    chk_irq_gated: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        txn_irq_o && multi |-> xfer_complete_o && txn_done_o)
        else $error("interrupt between multipacket packets");
    chk_clip_limit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        txn_done_o |-> accepted_count_o <= max_payload)
        else $error("accepted count above payload limit");
    chk_out_complete: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        state_reg.st == usbd_pkg::ST_CALC && !state_reg.txn.is_in && multi && short_pkt
            |-> ##4 xfer_complete_o)
        else $error("short packet did not complete transfer");
endmodule

// ---- testbench/usbd_sram_model.sv ----
// Byte-wide SRAM partner seen through the descriptor walker's memory port.
// Assumes the bench preloads and inspects the array directly.
`timescale 1ns/1ps
module usbd_sram_model (
    // Clock
    input wire logic mclk_i,
    // Request and read data
    input wire usbd_pkg::usbd_mem_req_t mem_req_i,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [0:65535];

    initial begin
        mem_rdata_o = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hA5;
        end
    end

    always @(posedge mclk_i) begin
        if (mem_req_i.we) begin
            mem[mem_req_i.addr] <= mem_req_i.wdata;
        end
        // Data is not held, so a late sample sees garbage
        mem_rdata_o <= mem_req_i.re ? mem[mem_req_i.addr] : ~mem_rdata_o;
    end
endmodule

// ---- testbench/usbd_desc_frame_tb_top.sv ----
// Self-checking bench for the descriptor walker and frame recorder.
// Assumes the SRAM model's array may be written and read directly.
`timescale 1ns/1ps
module usbd_desc_frame_tb_top;
    typedef struct packed {
        logic [15:0] ptr;
        logic [9:0] count;
        logic cmpl;
        logic irq;
    } usbd_exp_t;
    localparam logic [15:0] BASE = 16'h0100;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sof_valid_i = 1'b0;
    usbd_pkg::usbd_sof_t sof_i = '0;
    logic txn_valid_i = 1'b0;
    usbd_pkg::usbd_txn_t txn_i = '0;
    logic txn_ready_o, txn_done_o, xfer_complete_o, txn_irq_o, sof_frame_error_o;
    logic [15:0] endpoint_buffer_pointer_o;
    logic [9:0] accepted_count_o;
    logic [10:0] sof_frame_number_o;
    usbd_pkg::usbd_mem_req_t mem_req_o;
    logic [7:0] mem_rdata_i;
    logic [31:0] lfsr = 32'hfef0;
    logic [15:0] v;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    usbd_exp_t exp_q[$];

    usbd_desc_frame u_usbd_desc_frame (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .descriptor_table_base_i(BASE), .highest_endpoint_index_i(4'h3),
        .sof_valid_i(sof_valid_i), .sof_i(sof_i),
        .txn_valid_i(txn_valid_i), .txn_i(txn_i), .txn_ready_o(txn_ready_o),
        .txn_done_o(txn_done_o), .endpoint_buffer_pointer_o(endpoint_buffer_pointer_o),
        .accepted_count_o(accepted_count_o), .xfer_complete_o(xfer_complete_o),
        .txn_irq_o(txn_irq_o), .sof_frame_number_o(sof_frame_number_o),
        .sof_frame_error_o(sof_frame_error_o), .mem_req_o(mem_req_o),
        .mem_rdata_i(mem_rdata_i)
    );
    usbd_sram_model u_usbd_sram_model (
        .mclk_i(mclk_i), .mem_req_i(mem_req_o), .mem_rdata_o(mem_rdata_i)
    );

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] desc_addr(input logic [3:0] ep, input logic in);
        return BASE + {8'h00, ep, 4'h0} + (in ? 16'h0008 : 16'h0000);
    endfunction

    task automatic fail(input string msg);
        bad_count++;
        $display("ERROR %0t %s", $time, msg);
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) fail(what);
    endtask

    task automatic cmp_txn(input usbd_exp_t e);
        cmp_count++;
        if ({endpoint_buffer_pointer_o, accepted_count_o, xfer_complete_o, txn_irq_o} !== e) begin
            fail("packet result");
        end
    endtask

    task automatic rd16(input logic [15:0] a, output logic [15:0] d);
        d = {u_usbd_sram_model.mem[a + 16'h1], u_usbd_sram_model.mem[a]};
    endtask

    task automatic set_desc(input logic [3:0] ep, input logic in, input logic [7:0] ctrl,
                            input logic [15:0] ptr, input logic [15:0] aux,
                            input logic [15:0] count);
        logic [15:0] d;
        d = desc_addr(ep, in);
        u_usbd_sram_model.mem[d + 16'h1] = ctrl;
        {u_usbd_sram_model.mem[d + 16'h3], u_usbd_sram_model.mem[d + 16'h2]} = count;
        {u_usbd_sram_model.mem[d + 16'h5], u_usbd_sram_model.mem[d + 16'h4]} = ptr;
        {u_usbd_sram_model.mem[d + 16'h7], u_usbd_sram_model.mem[d + 16'h6]} = aux;
    endtask

    task automatic send(input logic [3:0] ep, input logic in, input logic [9:0] n,
                        input usbd_exp_t e);
        int k;
        k = 0;
        exp_q.push_back(e);
        @(negedge mclk_i);
        txn_valid_i = 1'b1;
        txn_i = '{ep: ep, is_in: in, count: n};
        while (txn_ready_o !== 1'b1 && k < 40) begin
            @(negedge mclk_i);
            k++;
        end
        @(negedge mclk_i);
        txn_valid_i = 1'b0;
        while (exp_q.size() != 0 && k < 60) begin
            @(negedge mclk_i);
            k++;
        end
        if (exp_q.size() != 0) begin
            fail("no done");
            exp_q.delete();
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Oldest note is matched against each finished packet
    always @(negedge mclk_i) begin
        if (!sys_rst_i && txn_done_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("unexpected done");
            end else begin
                cmp_txn(exp_q.pop_front());
            end
        end
    end

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail("timeout");
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        @(negedge mclk_i);
        cmp_val({txn_ready_o, sof_frame_error_o, 3'h0, sof_frame_number_o}, 16'h8000,
                "reset");
        $display("reset test done");
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_step(lfsr);
            @(negedge mclk_i);
            sof_valid_i = 1'b1;
            sof_i = '{frame: lfsr[10:0], error: i[0]};
            @(negedge mclk_i);
            sof_valid_i = 1'b0;
            cmp_val({4'h0, sof_frame_error_o, sof_frame_number_o}, {4'h0, i[0], lfsr[10:0]},
                    "frame out");
            repeat (4) @(negedge mclk_i);
            rd16(BASE + 16'h0040, v);
            cmp_val(v, {i[0], 4'h0, lfsr[10:0]}, "frame bytes");
        end
        $display("frame test done");
        lfsr = lfsr_step(lfsr);
        set_desc(4'h0, 1'b1, 8'h83, lfsr[15:0], lfsr[31:16], 16'h0000);
        send(4'h0, 1'b1, {4'h0, lfsr[5:0]},
             '{lfsr[15:0], {4'h0, lfsr[5:0]}, 1'b0, 1'b1});
        rd16(desc_addr(4'h0, 1'b1) + 16'h6, v);
        cmp_val(v, lfsr[31:16], "aux in kept");
        set_desc(4'h1, 1'b0, 8'h80, lfsr[31:16], lfsr[15:0], 16'hFC00);
        send(4'h1, 1'b0, 10'd20, '{lfsr[31:16], 10'd8, 1'b0, 1'b1});
        rd16(desc_addr(4'h1, 1'b0) + 16'h2, v);
        cmp_val(v, 16'hFC08, "out count");
        rd16(desc_addr(4'h1, 1'b0) + 16'h6, v);
        cmp_val(v, lfsr[15:0], "aux out kept");
        $display("single packet test done");
        for (int c = 0; c < 8; c++) begin
            set_desc(4'h2, 1'b0, 8'hC0 | 8'(c), 16'h2000, 16'h0000, 16'h0000);
            send(4'h2, 1'b0, 10'h3FF,
                 '{16'h2000, (c == 7) ? 10'h3FF : 10'(8 << c), 1'b0, 1'b1});
        end
        $display("size code test done");
        set_desc(4'h3, 1'b1, 8'hA3, 16'h3000, 16'h0000, 16'h0000);
        send(4'h3, 1'b1, 10'd64, '{16'h3000, 10'd64, 1'b0, 1'b0});
        send(4'h3, 1'b1, 10'd10, '{16'h3000, 10'd10, 1'b1, 1'b1});
        rd16(desc_addr(4'h3, 1'b1) + 16'h6, v);
        cmp_val(v, 16'd74, "in total");
        set_desc(4'h3, 1'b0, 8'hA3, 16'h3100, 16'd128, 16'h0000);
        send(4'h3, 1'b0, 10'd64, '{16'h3100, 10'd64, 1'b0, 1'b0});
        send(4'h3, 1'b0, 10'd64, '{16'h3100, 10'd64, 1'b1, 1'b1});
        rd16(desc_addr(4'h3, 1'b0) + 16'h2, v);
        cmp_val(v, 16'd128, "out total");
        // Short packet ends a fresh OUT transfer before its total is reached
        set_desc(4'h3, 1'b0, 8'hA3, 16'h3100, 16'd128, 16'h0000);
        send(4'h3, 1'b0, 10'd10, '{16'h3100, 10'd10, 1'b1, 1'b1});
        rd16(desc_addr(4'h3, 1'b0) + 16'h2, v);
        cmp_val(v, 16'd10, "out short count");
        $display("multipacket test done");
        end_of_test();
    end
endmodule
